// File: inc/fspc_pkg.sv
// Shared constants and types for the flash self-program sequencer
package fspc_pkg;
   // Control/status bit positions
   localparam int BIT_STORE_EN = 0;
   localparam int BIT_ERASE = 1;
   localparam int BIT_WRITE = 2;
   localparam int BIT_LOCK = 3;
   localparam int BIT_REEN = 4;
   localparam int BIT_SIG = 5;
   localparam int BIT_BUSY = 6;
   localparam int BIT_IRQ_EN = 7;
   localparam logic [7:0] CSR_RESET = 8'h00;
   localparam logic [7:0] EXT_RESET = 8'h00;
   // Lock bits come up unprogrammed; programming keeps the outer pairs
   localparam logic [7:0] LOCK_RESET = 8'hFF;
   localparam logic [7:0] LOCK_KEEP = 8'hC3;
   // Accepted lower-five-bit command patterns
   localparam logic [4:0] CMD_LOAD = 5'h01;
   localparam logic [4:0] CMD_ERASE = 5'h03;
   localparam logic [4:0] CMD_WRITE = 5'h05;
   localparam logic [4:0] CMD_LOCK = 5'h09;
   localparam logic [4:0] CMD_REEN = 5'h11;
   // Signature read uses bit 5 with store enable
   localparam logic [5:0] CMD_SIG = 6'h21;
   // Instruction windows in cycles
   localparam logic [2:0] STORE_WINDOW = 3'h4;
   localparam logic [2:0] LOAD_WINDOW = 3'h3;
   // Register addresses on the plain port
   localparam logic [1:0] ADDR_CSR = 2'h0;
   localparam logic [1:0] ADDR_EXT = 2'h1;
   localparam logic [1:0] ADDR_LOCK = 2'h2;
   localparam int PTR_W = 24;
   localparam int WORD_W = 16;

   typedef enum {ST_IDLE, ST_ARMED, ST_ARRAY} fspc_state_t;

   // Command handed to the flash array
   typedef struct packed {
      logic erase;
      logic write;
      logic lock;
      logic [PTR_W-1:0] addr;
   } fspc_array_cmd_t;
endpackage : fspc_pkg

// File: src/fspc_page_buf.sv
// Temporary page buffer with per-word valid bits and registered read
`timescale 1ns/1ps
`default_nettype none
module fspc_page_buf #(
   parameter int WORDS = 128,
   parameter int AW = 7
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic clear_i,
   input wire logic wr_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [fspc_pkg::WORD_W-1:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [fspc_pkg::WORD_W-1:0] rdata_o,
   output logic loaded_o
);
   logic [fspc_pkg::WORD_W-1:0] mem [WORDS];
   logic [WORDS-1:0] valid_r;

   always_ff @(posedge clk_sys_i)
   begin
      if (wr_i)
      begin
         mem[waddr_i] <= wdata_i;
      end
      // Unloaded or cleared words read as erased
      rdata_o <= valid_r[raddr_i] ? mem[raddr_i] : '1;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         valid_r <= '0;
      end
      else
      begin
         // A load in the clearing cycle survives the clear
         if (clear_i)
         begin
            valid_r <= '0;
         end
         if (wr_i)
         begin
            valid_r[waddr_i] <= 1'b1;
         end
      end
   end

   assign loaded_o = |valid_r;
endmodule // fspc_page_buf
`default_nettype wire

// File: src/fspc_seq.sv
// Self-program control sequencer: control/status, pointer, buffer and array handshake
// Function
// - Ready interrupt requested while enable and global flag set and store enable clear.
// - Erase or write to upper section sets busy flag and blocks section.
// - Busy flag clears on re-enable after programming, or on a buffer load.
// - Signature read plus store enable: load returns signature byte, store does nothing.
// - Re-enable plus store enable: store re-enables section; not while busy.
// - Re-enable written during buffer loading aborts the load, dropping data.
// - Lock-set plus store enable: store programs boot locks from register zero.
// - Load within three cycles after lock-set returns lock or fuse bits.
// - Page write command writes buffer to page from upper pointer bits.
// - Processor stalled throughout page write to stalling section.
// - Page erase command erases page from upper pointer bits.
// - Erase of upper section keeps other readable; stalling section erase stalls.
// - Store enable alone: store puts registers one:zero into buffer word.
// - Store enable lasts four cycles, clears after store; held during erase/write.
// - Only accepted lower-five-bit patterns take effect; others ignored.
// - Word load addresses buffer by in-page word field of the pointer.
// - Page buffer clears after page write, on re-enable, and on reset.
// - Data memory write during buffer loading discards loaded data.
// - Target address latched at operation start; pointer free afterwards.
// - Pointer is extension byte above the two core pointer bytes.
// - Data memory write in progress blocks commands and fuse/lock reads.
`timescale 1ns/1ps
`default_nettype none
module fspc_seq #(
   parameter int PAGE_WORD_BITS = 7,
   parameter int STALL_SECT_BASE = 24'h01E000,
   parameter logic [7:0] FUSE_LOW = 8'hFF,
   parameter logic [7:0] FUSE_HIGH = 8'hFF,
   parameter logic [7:0] FUSE_EXT = 8'hFF
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Register port
   input wire logic [1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Core side
   input wire logic global_irq_en_i,
   input wire logic store_instr_i,
   input wire logic load_instr_i,
   input wire logic [15:0] core_ptr_i,
   input wire logic [7:0] gen_reg_zero_i,
   input wire logic [7:0] gen_reg_one_i,
   input wire logic data_mem_busy_i,
   input wire logic data_mem_write_i,
   output logic ready_irq_o,
   output logic cpu_stall_o,
   output logic upper_blocked_o,
   output logic load_override_o,
   output logic [7:0] load_data_o,
   // Signature row source
   output logic [7:0] sig_addr_o,
   input wire logic [7:0] sig_data_i,
   // Flash array
   output fspc_pkg::fspc_array_cmd_t array_cmd_o,
   output logic [fspc_pkg::WORD_W-1:0] array_wdata_o,
   output logic [7:0] array_lock_data_o,
   input wire logic array_done_i
);
   localparam int BUF_WORDS = 1 << PAGE_WORD_BITS;

   typedef struct packed {
      fspc_pkg::fspc_state_t st;
      logic [7:0] csr;
      logic [7:0] ext;
      logic [7:0] lock_bits;
      logic [2:0] win;
      logic [7:0] rdata;
      logic irq;
      logic stall;
      logic ovr;
      logic [7:0] ldata;
      logic [7:0] sig_addr;
      fspc_pkg::fspc_array_cmd_t cmd;
      logic [7:0] lock_wr;
   } fspc_state_s_t;

   fspc_state_s_t s_r;
   fspc_state_s_t s_nxt;

   logic [fspc_pkg::PTR_W-1:0] ptr;
   logic buf_wr;
   logic buf_clear;
   logic buf_loaded;
   logic [fspc_pkg::WORD_W-1:0] buf_rdata;
   logic [PAGE_WORD_BITS-1:0] buf_waddr;
   logic [4:0] low5;
   logic pat_ok;
   logic sig_ok;
   logic [7:0] fuse_byte;

   // Pointer assembly
   // extension byte on top
   assign ptr = {s_r.ext, core_ptr_i};
   // word field skips the byte bit
   assign buf_waddr = ptr[PAGE_WORD_BITS:1];
   assign low5 = reg_wdata_i[4:0];
   assign pat_ok = (low5 == fspc_pkg::CMD_LOAD) || (low5 == fspc_pkg::CMD_ERASE)
      || (low5 == fspc_pkg::CMD_WRITE) || (low5 == fspc_pkg::CMD_LOCK)
      || (low5 == fspc_pkg::CMD_REEN);
   assign sig_ok = reg_wdata_i[5:0] == fspc_pkg::CMD_SIG;

   // pointer low bits pick a fuse byte or the lock bits
   always_comb
   begin
      case (ptr[1:0])
         2'h0: fuse_byte = FUSE_LOW;
         2'h1: fuse_byte = s_r.lock_bits;
         2'h2: fuse_byte = FUSE_EXT;
         default: fuse_byte = FUSE_HIGH;
      endcase
   end

   always_comb
   begin
      logic csr_wr;
      logic [4:0] cmd5;
      logic to_stall;
      csr_wr = reg_wr_i && (reg_addr_i == fspc_pkg::ADDR_CSR);
      cmd5 = s_r.csr[4:0];
      to_stall = ptr >= fspc_pkg::PTR_W'(STALL_SECT_BASE);
      s_nxt = s_r;
      buf_wr = 1'b0;
      buf_clear = 1'b0;
      s_nxt.ovr = 1'b0;
      s_nxt.rdata = 8'h00;

      // Register reads, data one cycle later
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            fspc_pkg::ADDR_CSR: s_nxt.rdata = s_r.csr;
            fspc_pkg::ADDR_EXT: s_nxt.rdata = s_r.ext;
            fspc_pkg::ADDR_LOCK: s_nxt.rdata = s_r.lock_bits;
            default: s_nxt.rdata = 8'h00;
         endcase
      end

      if (reg_wr_i && (reg_addr_i == fspc_pkg::ADDR_EXT))
      begin
         s_nxt.ext = reg_wdata_i;
      end

      // data memory write kills a partial load
      // A running page write keeps its buffer; only loading is disturbed
      if (data_mem_write_i && buf_loaded && !s_r.cmd.write)
      begin
         buf_clear = 1'b1;
      end

      case (s_r.st)
         fspc_pkg::ST_IDLE:
         begin
            if (csr_wr)
            begin
               s_nxt.csr[fspc_pkg::BIT_IRQ_EN] = reg_wdata_i[fspc_pkg::BIT_IRQ_EN];
               // commands blocked during data memory write
               if (!data_mem_busy_i && (pat_ok || sig_ok))
               begin
                  s_nxt.csr[5:0] = reg_wdata_i[5:0];
                  s_nxt.win = 3'h0;
                  s_nxt.st = fspc_pkg::ST_ARMED;
                  if (reg_wdata_i[fspc_pkg::BIT_REEN])
                  begin
                     buf_clear = 1'b1;
                  end
               end
            end
         end
         fspc_pkg::ST_ARMED:
         begin
            // Window slot counts cycles since the arming write
            s_nxt.win = s_r.win + 3'h1;
            if (csr_wr)
            begin
               s_nxt.csr[fspc_pkg::BIT_IRQ_EN] = reg_wdata_i[fspc_pkg::BIT_IRQ_EN];
            end
            // lock or fuse readout on load
            if (load_instr_i && cmd5 == fspc_pkg::CMD_LOCK && s_r.win < fspc_pkg::LOAD_WINDOW
               && !data_mem_busy_i)
            begin
               s_nxt.ovr = 1'b1;
               s_nxt.ldata = fuse_byte;
               s_nxt.csr[5:0] = 6'h00;
               s_nxt.st = fspc_pkg::ST_IDLE;
            end
            else if (load_instr_i && s_r.csr[fspc_pkg::BIT_SIG] && s_r.win < fspc_pkg::LOAD_WINDOW)
            begin
               s_nxt.ovr = 1'b1;
               s_nxt.ldata = sig_data_i;
               s_nxt.csr[5:0] = 6'h00;
               s_nxt.st = fspc_pkg::ST_IDLE;
            end
            // stores refused during data memory write
            else if (store_instr_i && !data_mem_busy_i)
            begin
               s_nxt.csr[5:0] = 6'h00;
               s_nxt.st = fspc_pkg::ST_IDLE;
               // store under signature read does nothing
               if (!s_r.csr[fspc_pkg::BIT_SIG])
               begin
                  case (cmd5)
                     fspc_pkg::CMD_LOAD:
                     begin
                        buf_wr = 1'b1;
                        s_nxt.csr[fspc_pkg::BIT_BUSY] = 1'b0;
                     end
                     fspc_pkg::CMD_REEN:
                     begin
                        s_nxt.csr[fspc_pkg::BIT_BUSY] = 1'b0;
                     end
                     fspc_pkg::CMD_LOCK, fspc_pkg::CMD_ERASE, fspc_pkg::CMD_WRITE:
                     begin
                        s_nxt.csr[5:0] = s_r.csr[5:0];
                        s_nxt.cmd.addr = ptr;
                        s_nxt.cmd.lock = cmd5 == fspc_pkg::CMD_LOCK;
                        s_nxt.lock_wr = gen_reg_zero_i;
                        s_nxt.cmd.erase = cmd5 == fspc_pkg::CMD_ERASE;
                        s_nxt.cmd.write = cmd5 == fspc_pkg::CMD_WRITE;
                        if (cmd5 != fspc_pkg::CMD_LOCK && !to_stall)
                        begin
                           s_nxt.csr[fspc_pkg::BIT_BUSY] = 1'b1;
                        end
                        s_nxt.stall = cmd5 != fspc_pkg::CMD_LOCK && to_stall;
                        s_nxt.st = fspc_pkg::ST_ARRAY;
                     end
                     default: s_nxt.csr[5:0] = 6'h00;
                  endcase
               end
            end
            else if (s_r.win == fspc_pkg::STORE_WINDOW - 3'h1)
            begin
               s_nxt.csr[5:0] = 6'h00;
               s_nxt.st = fspc_pkg::ST_IDLE;
            end
         end
         fspc_pkg::ST_ARRAY:
         begin
            // only the enable bit is taken while the array is busy
            if (csr_wr)
            begin
               s_nxt.csr[fspc_pkg::BIT_IRQ_EN] = reg_wdata_i[fspc_pkg::BIT_IRQ_EN];
            end
            if (array_done_i)
            begin
               if (s_r.cmd.lock)
               begin
                  // Programming only clears bits; the outer pairs stay
                  s_nxt.lock_bits = s_r.lock_bits & (s_r.lock_wr | fspc_pkg::LOCK_KEEP);
               end
               if (s_r.cmd.write)
               begin
                  buf_clear = 1'b1;
               end
               s_nxt.cmd.erase = 1'b0;
               s_nxt.cmd.write = 1'b0;
               s_nxt.cmd.lock = 1'b0;
               s_nxt.stall = 1'b0;
               s_nxt.csr[5:0] = 6'h00;
               s_nxt.st = fspc_pkg::ST_IDLE;
            end
         end
         default: s_nxt.st = fspc_pkg::ST_IDLE;
      endcase

      // Signature byte address trails the pointer by one cycle
      s_nxt.sig_addr = ptr[7:0];
      // ready interrupt while store enable clear
      s_nxt.irq = s_nxt.csr[fspc_pkg::BIT_IRQ_EN] && global_irq_en_i
         && !s_nxt.csr[fspc_pkg::BIT_STORE_EN];
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         s_r <= '0;
         s_r.st <= fspc_pkg::ST_IDLE;
         s_r.csr <= fspc_pkg::CSR_RESET;
         s_r.ext <= fspc_pkg::EXT_RESET;
         // Lock bits come up unprogrammed
         s_r.lock_bits <= fspc_pkg::LOCK_RESET;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // buffer cleared on reset inside the buffer
   fspc_page_buf #(
      .WORDS(BUF_WORDS),
      .AW(PAGE_WORD_BITS)
   ) u_buf (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .clear_i(buf_clear),
      .wr_i(buf_wr),
      .waddr_i(buf_waddr),
      .wdata_i({gen_reg_one_i, gen_reg_zero_i}),
      // Array sees the word at the latched word address
      .raddr_i(s_r.cmd.addr[PAGE_WORD_BITS:1]),
      .rdata_o(buf_rdata),
      .loaded_o(buf_loaded)
   );

   assign reg_rdata_o = s_r.rdata;
   assign ready_irq_o = s_r.irq;
   assign cpu_stall_o = s_r.stall;
   assign upper_blocked_o = s_r.csr[fspc_pkg::BIT_BUSY];
   assign load_override_o = s_r.ovr;
   assign load_data_o = s_r.ldata;
   assign sig_addr_o = s_r.sig_addr;
   assign array_cmd_o = s_r.cmd;
   assign array_wdata_o = buf_rdata;
   assign array_lock_data_o = s_r.lock_wr;
endmodule // fspc_seq
`default_nettype wire

// File: dv/fspc_seq_monitor.sv
// Port-level assertion checker for the flash self-program sequencer
`timescale 1ns/1ps
`default_nettype none
module fspc_seq_monitor #(
   parameter int STALL_SECT_BASE = 24'h01E000
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic global_irq_en_i,
   input wire logic load_instr_i,
   input wire logic data_mem_busy_i,
   input wire logic ready_irq_o,
   input wire logic cpu_stall_o,
   input wire logic upper_blocked_o,
   input wire logic load_override_o,
   input wire fspc_pkg::fspc_array_cmd_t array_cmd_o,
   input wire logic array_done_i
);
   logic active;
   logic in_stall;
   assign active = array_cmd_o.erase | array_cmd_o.write;
   assign in_stall = {8'h00, array_cmd_o.addr} >= 32'(STALL_SECT_BASE);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);
   cmd_hold_a: assert property (active && !array_done_i |=> active)
      else $error("array command dropped before completion");
   addr_latch_a: assert property (active && !array_done_i |=> $stable(array_cmd_o.addr))
      else $error("target address moved during operation");
   done_clear_a: assert property (active && array_done_i |=> !active && !cpu_stall_o)
      else $error("command or stall kept after completion");
   stall_sect_a: assert property (active |-> cpu_stall_o == in_stall)
      else $error("stall does not match target section");
   busy_sect_a: assert property (active && !in_stall |-> upper_blocked_o)
      else $error("busy flag clear during upper section operation");
   stall_only_a: assert property (cpu_stall_o |-> active)
      else $error("stall without erase or write");
   irq_quiet_a: assert property (active |-> !ready_irq_o)
      else $error("ready request while operation runs");
   irq_gate_a: assert property (!global_irq_en_i [*2] |-> !ready_irq_o)
      else $error("ready request without global enable");
   override_a: assert property (load_override_o |-> $past(load_instr_i) && !$past(load_override_o))
      else $error("load override without a load");
   dm_block_a: assert property (data_mem_busy_i [*4] |=> !$rose(active))
      else $error("command started during data memory write");
   cover property (active && in_stall);
   cover property (active && !in_stall);
   cover property (load_override_o);
   cover property (ready_irq_o);
endmodule // fspc_seq_monitor
bind fspc_seq fspc_seq_monitor #(.STALL_SECT_BASE(STALL_SECT_BASE)) u_fspc_mon (
   .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .global_irq_en_i(global_irq_en_i),
   .load_instr_i(load_instr_i), .data_mem_busy_i(data_mem_busy_i), .ready_irq_o(ready_irq_o),
   .cpu_stall_o(cpu_stall_o), .upper_blocked_o(upper_blocked_o),
   .load_override_o(load_override_o), .array_cmd_o(array_cmd_o), .array_done_i(array_done_i));
`default_nettype wire

// File: dv/fspc_array_model.sv
// Flash array and signature row model facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module fspc_array_model #(
   parameter int DELAY = 6
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire fspc_pkg::fspc_array_cmd_t cmd_i,
   input wire logic [7:0] sig_addr_i,
   output logic done_o,
   output logic [7:0] sig_data_o
);
   logic [7:0] cnt_r;
   logic fired_r;
   assign sig_data_o = ~sig_addr_i ^ 8'h5A;
   always_ff @(posedge clk_sys_i)
   begin
      done_o <= 1'b0;
      if (!rst_b_i || !(cmd_i.erase | cmd_i.write | cmd_i.lock))
      begin
         cnt_r <= 8'h00;
         fired_r <= 1'b0;
      end
      else if (!fired_r && cnt_r == 8'(DELAY))
      begin
         done_o <= 1'b1;
         fired_r <= 1'b1;
      end
      else
         cnt_r <= cnt_r + 8'h01;
   end
endmodule // fspc_array_model
`default_nettype wire

// File: dv/flash_self_program_control_tb.sv
// Self-checking testbench for the flash self-program sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_control_tb;
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [1:0] reg_addr_i = 2'h0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic global_irq_en_i = 1'b0;
   logic store_instr_i = 1'b0;
   logic load_instr_i = 1'b0;
   logic [15:0] core_ptr_i = 16'h0000;
   logic [7:0] gen_reg_zero_i = 8'h00;
   logic [7:0] gen_reg_one_i = 8'h00;
   logic data_mem_busy_i = 1'b0;
   logic data_mem_write_i = 1'b0;
   logic [7:0] reg_rdata_o, load_data_o, sig_addr_o, sig_data_i, array_lock_data_o, rd;
   logic ready_irq_o, cpu_stall_o, upper_blocked_o, load_override_o, array_done_i;
   logic [15:0] array_wdata_o;
   fspc_pkg::fspc_array_cmd_t array_cmd_o;
   int bad_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   typedef struct {logic [7:0] wr; logic [7:0] rb;} fspc_row_t;
   fspc_row_t rows [10] = '{'{8'h01, 8'h01}, '{8'h03, 8'h03}, '{8'h05, 8'h05},
      '{8'h09, 8'h09}, '{8'h11, 8'h11}, '{8'h21, 8'h21}, '{8'h07, 8'h00},
      '{8'h02, 8'h00}, '{8'h19, 8'h00}, '{8'h81, 8'h81}};
   fspc_seq uut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .global_irq_en_i(global_irq_en_i),
      .store_instr_i(store_instr_i), .load_instr_i(load_instr_i), .core_ptr_i(core_ptr_i),
      .gen_reg_zero_i(gen_reg_zero_i), .gen_reg_one_i(gen_reg_one_i),
      .data_mem_busy_i(data_mem_busy_i), .data_mem_write_i(data_mem_write_i),
      .ready_irq_o(ready_irq_o), .cpu_stall_o(cpu_stall_o), .upper_blocked_o(upper_blocked_o),
      .load_override_o(load_override_o), .load_data_o(load_data_o), .sig_addr_o(sig_addr_o),
      .sig_data_i(sig_data_i), .array_cmd_o(array_cmd_o), .array_wdata_o(array_wdata_o),
      .array_lock_data_o(array_lock_data_o), .array_done_i(array_done_i));
   fspc_array_model #(.DELAY(12)) u_array (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
      .cmd_i(array_cmd_o), .sig_addr_i(sig_addr_o), .done_o(array_done_i),
      .sig_data_o(sig_data_i));
   initial
   begin
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   task automatic finish_test();
      if (bad_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input string nm, input logic [23:0] e, input logic [23:0] g);
      samples_checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
      #1;
   endtask
   task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask
   task automatic arm_store(input logic [7:0] cmd, input int gap);
      reg_write(fspc_pkg::ADDR_CSR, cmd);
      idle(gap);
      store_instr_i <= 1'b1;
      @(posedge clk_sys_i);
      store_instr_i <= 1'b0;
      #1;
   endtask
   task automatic load_chk(input logic [15:0] p, input logic [7:0] cmd, input logic [7:0] e);
      core_ptr_i <= p;
      reg_write(fspc_pkg::ADDR_CSR, cmd);
      load_instr_i <= 1'b1;
      @(posedge clk_sys_i);
      load_instr_i <= 1'b0;
      #1;
      check("load override", 24'h1, load_override_o);
      check("load data", e, load_data_o);
   endtask
   task automatic wait_idle();
      int i;
      for (i = 0; i < 60; i++)
      begin
         @(posedge clk_sys_i);
         #1;
         if (!(array_cmd_o.erase || array_cmd_o.write || array_cmd_o.lock)) break;
      end
      check("array idle", 24'h0, 24'(i == 60));
   endtask
   task automatic csr_is(input string nm, input logic [7:0] e);
      reg_read(fspc_pkg::ADDR_CSR, rd);
      check(nm, e, rd);
   endtask
   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         bad_count++;
         finish_test();
      end
   end
   initial
   begin
      idle(4);
      rst_b_i <= 1'b1;
      foreach (rows[k])
      begin
         reg_write(fspc_pkg::ADDR_CSR, rows[k].wr);
         csr_is("csr accept", rows[k].rb);
         idle(5);
         csr_is("csr expiry", rows[k].rb & 8'hC0);
         reg_write(fspc_pkg::ADDR_CSR, 8'h00);
      end
      rst_b_i <= 1'b0;
      idle(4);
      rst_b_i <= 1'b1;
      csr_is("csr reset", fspc_pkg::CSR_RESET);
      reg_read(fspc_pkg::ADDR_EXT, rd);
      check("ext reset", fspc_pkg::EXT_RESET, rd);
      reg_read(fspc_pkg::ADDR_LOCK, rd);
      check("lock reset", 8'hFF, rd);
      reg_read(2'h3, rd);
      check("unmapped", 8'h00, rd);
      core_ptr_i <= 16'h0102;
      gen_reg_zero_i <= 8'h34;
      gen_reg_one_i <= 8'h12;
      arm_store(8'h01, 0);
      csr_is("csr after load", 8'h00);
      arm_store(8'h05, 1);
      core_ptr_i <= 16'hFFFF;
      idle(3);
      #1;
      check("write cmd", 24'h1, array_cmd_o.write);
      check("write page", 24'h0001, array_cmd_o.addr[23:8]);
      check("busy flag", 24'h1, upper_blocked_o);
      check("no stall", 24'h0, cpu_stall_o);
      check("buffer word", 24'h1234, array_wdata_o);
      wait_idle();
      csr_is("busy kept", 8'h40);
      arm_store(8'h11, 0);
      csr_is("busy cleared", 8'h00);
      core_ptr_i <= 16'h0102;
      gen_reg_zero_i <= 8'h78;
      arm_store(8'h01, 0);
      arm_store(8'h11, 0);
      arm_store(8'h05, 1);
      idle(3);
      #1;
      check("buffer dropped", 24'h00FFFF, array_wdata_o);
      wait_idle();
      arm_store(8'h01, 0);
      csr_is("busy load clear", 8'h00);
      data_mem_write_i <= 1'b1;
      idle(1);
      data_mem_write_i <= 1'b0;
      arm_store(8'h05, 1);
      idle(3);
      #1;
      check("buffer lost", 24'h00FFFF, array_wdata_o);
      wait_idle();
      arm_store(8'h11, 0);
      reg_write(fspc_pkg::ADDR_EXT, 8'h01);
      reg_read(fspc_pkg::ADDR_EXT, rd);
      check("ext reg", 8'h01, rd);
      core_ptr_i <= 16'hE000;
      arm_store(8'h03, 4);
      idle(2);
      #1;
      check("late store", 24'h0, array_cmd_o.erase);
      arm_store(8'h03, 3);
      idle(2);
      #1;
      check("erase cmd", 24'h1, array_cmd_o.erase);
      check("erase stall", 24'h1, cpu_stall_o);
      check("no busy", 24'h0, upper_blocked_o);
      wait_idle();
      check("stall released", 24'h0, cpu_stall_o);
      reg_write(fspc_pkg::ADDR_EXT, 8'h00);
      load_chk(16'h0001, 8'h09, 8'hFF);
      load_chk(16'h0000, 8'h09, 8'hFF);
      load_chk(16'h0004, 8'h21, ~8'h04 ^ 8'h5A);
      gen_reg_zero_i <= 8'hC3;
      arm_store(8'h09, 0);
      wait_idle();
      load_chk(16'h0001, 8'h09, 8'hC3);
      global_irq_en_i <= 1'b1;
      reg_write(fspc_pkg::ADDR_CSR, 8'h80);
      idle(2);
      #1;
      check("ready irq", 24'h1, ready_irq_o);
      global_irq_en_i <= 1'b0;
      reg_write(fspc_pkg::ADDR_CSR, 8'h00);
      data_mem_busy_i <= 1'b1;
      reg_write(fspc_pkg::ADDR_CSR, 8'h03);
      idle(3);
      csr_is("dm busy refuse", 8'h00);
      data_mem_busy_i <= 1'b0;
      finish_test();
   end
endmodule // flash_self_program_control_tb
`default_nettype wire
